// File: hdl/spsc_pkg.sv
`default_nettype none
package spsc_pkg;
    // clock and press timing
    localparam int CLK_HZ = 100_000_000;
    localparam int HOLD_TIME_MS = 4000;
    localparam int DEB_TIME_MS = 10;
    localparam int HOLD_CYC = HOLD_TIME_MS * (CLK_HZ / 1000);
    localparam int DEB_CYC = DEB_TIME_MS * (CLK_HZ / 1000);

    // power states, g3 means no ac power at all
    typedef enum logic [2:0] {
        ST_G3 = 3'h0,
        ST_S0 = 3'h1,
        ST_S1 = 3'h2,
        ST_S3 = 3'h3,
        ST_S4 = 3'h4,
        ST_S5 = 3'h5
    } spsc_state_t;

    // register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_INT_STAT = 8'h0C;
    localparam logic [7:0] ADDR_INT_MASK = 8'h10;

    // control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_SLEEP_S3 = 0;
    localparam int CTRL_PME_EN = 1;
    localparam int CTRL_S5_NET_EN = 2;
    localparam int CTRL_LAST_STATE = 3;
    localparam int CTRL_DUAL_LED = 4;
    localparam logic [4:0] CTRL_RESET = 5'h19;

    // command register: target state code in the low bits
    localparam int CMD_W = 3;

    // status register fields
    localparam int STS_STATE_LSB = 0;
    localparam int STS_LAST_ON = 3;
    localparam int STS_SW_HELD = 4;
    localparam int STS_WAKE_LSB = 5;

    // wake source indices
    localparam int WK_RISER = 0;
    localparam int WK_RTC = 1;
    localparam int WK_USB = 2;
    localparam int WK_PS2 = 3;
    localparam int WK_MODEM = 4;
    localparam int WK_LAN = 5;
    localparam int WK_PME = 6;
    localparam int WK_N = 7;

    // interrupt status bits
    localparam int INT_W = 5;
    localparam int IRQ_STATE = 0;
    localparam int IRQ_WAKE = 1;
    localparam int IRQ_SHORT = 2;
    localparam int IRQ_LONG = 3;
    localparam int IRQ_ACFAIL = 4;
    localparam logic [4:0] INT_MASK_RESET = 5'h00;
endpackage
`default_nettype wire

// File: hdl/spsc_sw_if.sv
`timescale 1ns/10ps
`default_nettype none
interface spsc_sw_if;
    logic held;
    logic short_press;
    logic long_press;
    modport src (output held, output short_press, output long_press);
    modport dst (input held, input short_press, input long_press);
endinterface
`default_nettype wire

// File: hdl/spsc_switch.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_switch #(
    parameter int unsigned HOLD_CYCLES = spsc_pkg::HOLD_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = spsc_pkg::DEB_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic pwr_sw_n,
    spsc_sw_if.src sw
);
    import spsc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic [31:0] deb_cnt;
        logic [31:0] hold_cnt;
        logic long_done;
        logic short_p;
        logic long_p;
    } spsc_sw_st_t;

    spsc_sw_st_t s_r;
    spsc_sw_st_t s_nxt;

    // debounce, then time the hold against the long-press threshold
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = ~pwr_sw_n;
        s_nxt.s2 = s_r.s1;
        s_nxt.short_p = 1'b0;
        s_nxt.long_p = 1'b0;
        if (s_r.s2 != s_r.level) begin
            if (s_r.deb_cnt >= DEBOUNCE_CYCLES - 1) begin
                s_nxt.level = s_r.s2;
                s_nxt.deb_cnt = 32'h0;
            end else begin
                s_nxt.deb_cnt = 32'(s_r.deb_cnt + 32'h1);
            end
        end else begin
            s_nxt.deb_cnt = 32'h0;
        end
        // counter saturates so a stuck switch never wraps to a second event
        if (s_r.level) begin
            if (s_r.hold_cnt < HOLD_CYCLES) begin
                s_nxt.hold_cnt = 32'(s_r.hold_cnt + 32'h1);
            end
            if (s_r.hold_cnt == HOLD_CYCLES - 1) begin
                s_nxt.long_p = 1'b1;
                s_nxt.long_done = 1'b1;
            end
        end else begin
            s_nxt.hold_cnt = 32'h0;
            s_nxt.long_done = 1'b0;
            // short press is reported on release, only if long never fired
            if (s_r.hold_cnt != 32'h0 && !s_r.long_done) begin
                s_nxt.short_p = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sw.held = s_r.level;
    assign sw.short_press = s_r.short_p;
    assign sw.long_press = s_r.long_p;

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_PRESS_KIND: assert property (
        s_r.long_p |-> $past(s_r.level) && !s_r.short_p
    ) else $error("long press without held switch or with short press");
endmodule
`default_nettype wire

// File: hdl/spsc_top.sv
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module spsc_top #(
    parameter int unsigned HOLD_CYCLES = spsc_pkg::HOLD_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = spsc_pkg::DEB_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [spsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [spsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [spsc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic pwr_sw_n,
    input wire logic ac_power_ok,
    input wire logic riser_wake,
    input wire logic rtc_alarm,
    input wire logic usb_wake,
    input wire logic ps2_wake,
    input wire logic modem_ring,
    input wire logic lan_wake,
    input wire logic pci_power_event_wake_n,
    output logic psu_on,
    output logic cpu_stop,
    output logic fan_cpu_en,
    output logic fan_front_en,
    output logic fan_rear_en,
    output logic led_power_green,
    output logic led_power_amber,
    output logic led_standby,
    output logic irq
);
    import spsc_pkg::*;

    typedef struct packed {
        logic ac1;
        logic ac2;
        logic [WK_N-1:0] wk1;
        logic [WK_N-1:0] wk2;
        spsc_state_t state;
        logic last_on;
        logic [CTRL_W-1:0] ctrl;
        logic [INT_W-1:0] int_stat;
        logic [INT_W-1:0] int_mask;
        logic [DATA_W-1:0] rdata;
        logic psu;
        logic fan;
        logic stop;
        logic led_g;
        logic led_a;
        logic led_sb;
    } spsc_top_st_t;

    spsc_top_st_t s_r;
    spsc_top_st_t s_nxt;
    spsc_sw_if sw_if ();
    logic [WK_N-1:0] wk_raw;
    logic wake_hit;
    logic cmd_wr;
    spsc_state_t cmd_tgt;

    // switch conditioning lives in its own module
    spsc_switch #(
        .HOLD_CYCLES(HOLD_CYCLES),
        .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
    ) u_switch (
        .clock(clock),
        .arst_n(arst_n),
        .pwr_sw_n(pwr_sw_n),
        .sw(sw_if.src)
    );

    // main rails and fans run only in S0 and S1
    function automatic logic is_running(input spsc_state_t st);
        is_running = (st == ST_S0) || (st == ST_S1);
    endfunction

    function automatic logic is_asleep(input spsc_state_t st);
        is_asleep = (st == ST_S1) || (st == ST_S3) ||
                    (st == ST_S4) || (st == ST_S5);
    endfunction

    // per-state eligibility of each wake source
    function automatic logic wake_ok(input spsc_state_t st,
                                     input logic [WK_N-1:0] src,
                                     input logic [CTRL_W-1:0] ctl);
        logic light;
        logic deep_ok;
        logic any;
        light = (st == ST_S1) || (st == ST_S3);
        deep_ok = (st != ST_S5) || ctl[CTRL_S5_NET_EN];
        any = src[WK_RISER] || src[WK_RTC];
        if (light && (src[WK_USB] || src[WK_PS2] || src[WK_MODEM])) begin
            any = 1'b1;
        end
        if (deep_ok && src[WK_LAN]) begin
            any = 1'b1;
        end
        if (deep_ok && ctl[CTRL_PME_EN] && src[WK_PME]) begin
            any = 1'b1;
        end
        wake_ok = is_asleep(st) && any;
    endfunction

    // the power-event line is active low, the rest active high
    assign wk_raw[WK_RISER] = riser_wake;
    assign wk_raw[WK_RTC] = rtc_alarm;
    assign wk_raw[WK_USB] = usb_wake;
    assign wk_raw[WK_PS2] = ps2_wake;
    assign wk_raw[WK_MODEM] = modem_ring;
    assign wk_raw[WK_LAN] = lan_wake;
    assign wk_raw[WK_PME] = ~pci_power_event_wake_n;

    // decode of the command write and the wake qualifier
    assign wake_hit = wake_ok(s_r.state, s_r.wk2, s_r.ctrl);
    assign cmd_wr = reg_wr && (reg_addr == ADDR_CMD);
    assign cmd_tgt = spsc_state_t'(reg_wdata[CMD_W-1:0]);

    // next-state logic: ac loss first, then switch, wake, software
    always_comb begin
        s_nxt = s_r;
        s_nxt.ac1 = ac_power_ok;
        s_nxt.ac2 = s_r.ac1;
        s_nxt.wk1 = wk_raw;
        s_nxt.wk2 = s_r.wk1;
        if (!s_r.ac2) begin
            s_nxt.state = ST_G3;
        end else if (s_r.state == ST_G3) begin
            // a cold start reads as off, so default is soft-off
            if (s_r.ctrl[CTRL_LAST_STATE] && s_r.last_on) begin
                s_nxt.state = ST_S0;
            end else begin
                s_nxt.state = ST_S5;
            end
        end else if (sw_if.long_press && s_r.state != ST_S5) begin
            s_nxt.state = ST_S5;
        end else if (sw_if.short_press) begin
            if (s_r.state == ST_S0) begin
                s_nxt.state = s_r.ctrl[CTRL_SLEEP_S3] ? ST_S3 : ST_S1;
            end else begin
                s_nxt.state = ST_S0;
            end
        end else if (wake_hit) begin
            // last working state is always S0, S1, S3 and S4 are only entered from it
            s_nxt.state = ST_S0;
        end else if (cmd_wr) begin
            if (s_r.state == ST_S0 && is_asleep(cmd_tgt)) begin
                s_nxt.state = cmd_tgt;
            end else if (s_r.state == ST_S1 &&
                         (cmd_tgt == ST_S0 || cmd_tgt == ST_S5)) begin
                s_nxt.state = cmd_tgt;
            end
        end
        // remembered across the outage; frozen while in g3
        if (s_r.state != ST_G3) begin
            s_nxt.last_on = is_running(s_r.state);
        end

        // register writes, ahead of the outputs that depend on them
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            s_nxt.ctrl = reg_wdata[CTRL_W-1:0];
        end
        if (reg_wr && reg_addr == ADDR_INT_MASK) begin
            s_nxt.int_mask = reg_wdata[INT_W-1:0];
        end

        // outputs follow the next state so they stay flop-driven; standby follows the synced ac
        s_nxt.psu = is_running(s_nxt.state);
        s_nxt.fan = is_running(s_nxt.state);
        s_nxt.stop = (s_nxt.state == ST_S1);
        s_nxt.led_g = is_running(s_nxt.state);
        s_nxt.led_a = (s_nxt.state == ST_S3) &&
                      s_nxt.ctrl[CTRL_DUAL_LED];
        s_nxt.led_sb = s_r.ac2;

        // read data stands for exactly one cycle, unmapped reads zero
        s_nxt.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    s_nxt.rdata[CTRL_W-1:0] = s_r.ctrl;
                end
                ADDR_STATUS: begin
                    s_nxt.rdata[STS_STATE_LSB+:3] = s_r.state;
                    s_nxt.rdata[STS_LAST_ON] = s_r.last_on;
                    s_nxt.rdata[STS_SW_HELD] = sw_if.held;
                    s_nxt.rdata[STS_WAKE_LSB+:WK_N] = s_r.wk2;
                end
                ADDR_INT_STAT: begin
                    s_nxt.rdata[INT_W-1:0] = s_r.int_stat;
                end
                ADDR_INT_MASK: begin
                    s_nxt.rdata[INT_W-1:0] = s_r.int_mask;
                end
                default: begin
                    s_nxt.rdata = '0;
                end
            endcase
        end

        // sticky events; a read clears but a same-cycle event survives
        if (reg_rd && reg_addr == ADDR_INT_STAT) begin
            s_nxt.int_stat = '0;
        end
        if (s_nxt.state != s_r.state) begin
            s_nxt.int_stat[IRQ_STATE] = 1'b1;
        end
        if (wake_hit) begin
            s_nxt.int_stat[IRQ_WAKE] = 1'b1;
        end
        if (sw_if.short_press) begin
            s_nxt.int_stat[IRQ_SHORT] = 1'b1;
        end
        if (sw_if.long_press) begin
            s_nxt.int_stat[IRQ_LONG] = 1'b1;
        end
        if (!s_r.ac2 && s_r.state != ST_G3) begin
            s_nxt.int_stat[IRQ_ACFAIL] = 1'b1;
        end
    end

    // the one state register; reset leaves the system unpowered
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
            s_r.state <= ST_G3;
            s_r.ctrl <= CTRL_RESET;
            s_r.int_mask <= INT_MASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign reg_rdata = s_r.rdata;
    assign psu_on = s_r.psu;
    assign cpu_stop = s_r.stop;
    assign fan_cpu_en = s_r.fan;
    assign fan_front_en = s_r.fan;
    assign fan_rear_en = s_r.fan;
    assign led_power_green = s_r.led_g;
    assign led_power_amber = s_r.led_a;
    assign led_standby = s_r.led_sb;
    assign irq = |(s_r.int_stat & s_r.int_mask);

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // common guard: powered and no switch event this cycle
    sequence quiet_s;
        s_r.ac2 && !sw_if.long_press && !sw_if.short_press;
    endsequence

    sequence soft_off_cmd_s;
        s_r.state == ST_S0 && cmd_wr && cmd_tgt == ST_S5 &&
        !wake_hit && s_r.ac2 && !sw_if.long_press && !sw_if.short_press;
    endsequence

    sequence ac_back_s;
        s_r.state == ST_G3 && s_r.ac2 &&
        s_r.ctrl[CTRL_LAST_STATE] && s_r.last_on;
    endsequence

    AST_OFF_SHORT_ON: assert property (
        s_r.state == ST_S5 && sw_if.short_press && s_r.ac2
        |=> s_r.state == ST_S0 && psu_on
    ) else $error("short press in soft-off did not power on");

    AST_ON_SHORT_SLEEP: assert property (
        s_r.state == ST_S0 && sw_if.short_press && s_r.ac2
        |=> s_r.state == ST_S1 || s_r.state == ST_S3
    ) else $error("short press while working did not sleep");

    AST_ON_LONG_OFF: assert property (
        s_r.state == ST_S0 && sw_if.long_press && s_r.ac2
        |=> s_r.state == ST_S5 && !psu_on && !fan_cpu_en
    ) else $error("long press while working did not force soft-off");

    AST_SLEEP_SHORT_WAKE: assert property (
        (s_r.state == ST_S1 || s_r.state == ST_S3) &&
        sw_if.short_press && s_r.ac2
        |=> s_r.state == ST_S0
    ) else $error("short press while sleeping did not wake");

    AST_SLEEP_LONG_OFF: assert property (
        (s_r.state == ST_S1 || s_r.state == ST_S3 || s_r.state == ST_S4) &&
        sw_if.long_press && s_r.ac2
        |=> s_r.state == ST_S5
    ) else $error("long press while sleeping did not go to soft-off");

    AST_ALARM_S5: assert property (
        s_r.state == ST_S5 && s_r.wk2[WK_RTC] ##0 quiet_s
        |=> s_r.state == ST_S0
    ) else $error("clock alarm did not wake from soft-off");

    AST_LIGHT_ONLY: assert property (
        (s_r.state == ST_S4 || s_r.state == ST_S5) && !cmd_wr &&
        (s_r.wk2 & ~((WK_N)'(1 << WK_USB) | (WK_N)'(1 << WK_PS2) |
        (WK_N)'(1 << WK_MODEM))) == '0 ##0 quiet_s
        |=> s_r.state == $past(s_r.state)
    ) else $error("usb, keyboard or ring woke a deep sleep state");

    AST_S5_NET_GATE: assert property (
        s_r.state == ST_S5 && !s_r.ctrl[CTRL_S5_NET_EN] && !cmd_wr &&
        (s_r.wk2 & ~((WK_N)'(1 << WK_LAN) | (WK_N)'(1 << WK_PME))) == '0
        ##0 quiet_s
        |=> s_r.state == ST_S5
    ) else $error("network or power event woke soft-off while disabled");

    AST_PME_WAKE: assert property (
        s_r.state == ST_S4 && s_r.wk2[WK_PME] && s_r.ctrl[CTRL_PME_EN]
        ##0 quiet_s
        |=> s_r.state == ST_S0 && fan_rear_en
    ) else $error("enabled power event did not wake from S4");

    AST_FANS_TIED: assert property (
        fan_cpu_en == fan_front_en && fan_front_en == fan_rear_en &&
        fan_cpu_en == is_running(s_r.state)
    ) else $error("fan enables disagree with the power state");

    AST_SOFT_OFF: assert property (
        soft_off_cmd_s |=> s_r.state == ST_S5 && !psu_on && led_standby
    ) else $error("soft-off command left main supply on or dropped standby");

    AST_AC_RESTORE: assert property (
        ac_back_s |=> s_r.state == ST_S0 && psu_on
    ) else $error("previous on state not restored after ac return");

    AST_LAN_WAKE: assert property (
        s_r.state == ST_S3 && s_r.wk2[WK_LAN] ##0 quiet_s
        |=> s_r.state == ST_S0
    ) else $error("network wake request did not power up");

    AST_S3_LED: assert property (
        s_r.state == ST_S3 && $past(s_r.state) == ST_S3
        |-> !psu_on && !led_power_green &&
            led_power_amber == s_r.ctrl[CTRL_DUAL_LED]
    ) else $error("S3 supply or indicator wrong");

    AST_S3_RISER: assert property (
        s_r.state == ST_S3 && s_r.wk2[WK_RISER] ##0 quiet_s
        |=> s_r.state == ST_S0 && psu_on && led_power_green
    ) else $error("valid wake in S3 did not return to working");
endmodule
`default_nettype wire

// File: tb/spsc_partner.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_partner (
    input wire logic clock,
    output logic pwr_sw_n,
    output logic ac_power_ok,
    output logic [spsc_pkg::WK_N-1:0] wake
);
    import spsc_pkg::*;

    // idle levels: the switch pin rests high on its pull-up, ac present
    initial begin
        pwr_sw_n = 1'b1;
        ac_power_ok = 1'b1;
        wake = '0;
    end

    // hold the switch down, then let the pull-up take the pin back
    task automatic press(input int cyc);
        @(posedge clock);
        pwr_sw_n <= 1'b0;
        repeat (cyc) @(posedge clock);
        pwr_sw_n <= 1'b1;
        repeat (30) @(posedge clock);
    endtask

    // a source raises its request long enough to cross the synchroniser
    task automatic pulse_wake(input int idx);
        @(posedge clock);
        wake[idx] <= 1'b1;
        repeat (12) @(posedge clock);
        wake[idx] <= 1'b0;
        repeat (4) @(posedge clock);
    endtask

    // mains loss or return, then time for the sync stages
    task automatic set_ac(input logic v);
        @(posedge clock);
        ac_power_ok <= v;
        repeat (12) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// File: tb/spsc_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module spsc_top_tb;
    import spsc_pkg::*;

    // short counts keep the run small; expectations follow from these
    localparam int HOLD = 200;
    localparam int DEB = 4;
    localparam int SHORT = 20;
    localparam int LONG = HOLD + 30;
    localparam spsc_state_t SLEEPS [4] = '{ST_S1, ST_S3, ST_S4, ST_S5};

    logic clock;
    logic arst_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic pwr_sw_n;
    logic ac_power_ok;
    logic [WK_N-1:0] wake;
    logic pme_n;
    logic psu_on;
    logic cpu_stop;
    logic fan_cpu_en;
    logic fan_front_en;
    logic fan_rear_en;
    logic led_power_green;
    logic led_power_amber;
    logic led_standby;
    logic irq;
    int err_count = 0;
    int samples_checked = 0;
    // expected indicator style, follows the bench's own control writes
    logic dual_led = 1'b1;

    // the power-event line is active low at the pin
    assign pme_n = ~wake[WK_PME];

    spsc_partner u_part (
        .clock(clock),
        .pwr_sw_n(pwr_sw_n),
        .ac_power_ok(ac_power_ok),
        .wake(wake)
    );

    spsc_top #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB)) u_dut (
        .clock(clock),
        .arst_n(arst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .pwr_sw_n(pwr_sw_n),
        .ac_power_ok(ac_power_ok),
        .riser_wake(wake[WK_RISER]),
        .rtc_alarm(wake[WK_RTC]),
        .usb_wake(wake[WK_USB]),
        .ps2_wake(wake[WK_PS2]),
        .modem_ring(wake[WK_MODEM]),
        .lan_wake(wake[WK_LAN]),
        .pci_power_event_wake_n(pme_n),
        .psu_on(psu_on),
        .cpu_stop(cpu_stop),
        .fan_cpu_en(fan_cpu_en),
        .fan_front_en(fan_front_en),
        .fan_rear_en(fan_rear_en),
        .led_power_green(led_power_green),
        .led_power_amber(led_power_amber),
        .led_standby(led_standby),
        .irq(irq)
    );

    // free-running system clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask

    // bounded poll of the state field, then the outputs that state implies
    task automatic expect_st(input spsc_state_t st);
        logic [31:0] v;
        logic on;
        on = (st == ST_S0) || (st == ST_S1);
        for (int i = 0; i < 60; i++) begin
            rd(ADDR_STATUS, v);
            if (v[2:0] === st) break;
        end
        check({29'h0, v[2:0]}, {29'h0, st});
        check({27'h0, fan_cpu_en, fan_front_en, fan_rear_en, psu_on,
            led_power_green}, {27'h0, {5{on}}});
        check({30'h0, led_power_amber, cpu_stop},
            {30'h0, st == ST_S3 && dual_led, st == ST_S1});
    endtask

    // hang guard: a run that outlives this counts as a mismatch
    initial begin
        repeat (100000) @(posedge clock);
        err_count++;
        wrap_up();
    end

    // main sequence
    initial begin
        logic [31:0] v;
        logic [31:0] ctl;
        logic el;
        spsc_state_t st;
        logic lt;
        logic dp;
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rd(ADDR_CTRL, v);
        check(v, 32'h19);
        rd(ADDR_INT_MASK, v);
        check(v, 32'h0);
        rd(8'h3C, v);
        check(v, 32'h0);
        expect_st(ST_S5);
        u_part.press(2);
        expect_st(ST_S5);
        $display("test reset done");
        u_part.press(SHORT);
        expect_st(ST_S0);
        u_part.press(SHORT);
        expect_st(ST_S3);
        u_part.press(SHORT);
        expect_st(ST_S0);
        u_part.press(LONG);
        expect_st(ST_S5);
        u_part.press(SHORT);
        expect_st(ST_S0);
        wr(ADDR_CMD, {29'h0, ST_S1});
        expect_st(ST_S1);
        u_part.press(SHORT);
        expect_st(ST_S0);
        wr(ADDR_CMD, {29'h0, ST_S1});
        expect_st(ST_S1);
        u_part.press(LONG);
        expect_st(ST_S5);
        u_part.press(SHORT);
        expect_st(ST_S0);
        $display("test switch done");
        // every source from every sleep state, with and without enables
        for (int p = 0; p < 2; p++) begin
            ctl = (p == 0) ? 32'h19 : 32'h1F;
            wr(ADDR_CTRL, ctl);
            for (int k = 0; k < 4; k++) begin
                for (int s = 0; s < WK_N; s++) begin
                    st = SLEEPS[k];
                    lt = (st == ST_S1) || (st == ST_S3);
                    dp = (st != ST_S5) || ctl[CTRL_S5_NET_EN];
                    el = (s <= WK_RTC);
                    el |= (s <= WK_MODEM) && lt;
                    el |= (s == WK_LAN) && dp;
                    el |= (s == WK_PME) && dp && ctl[CTRL_PME_EN];
                    wr(ADDR_CMD, {29'h0, st});
                    expect_st(st);
                    u_part.pulse_wake(s);
                    expect_st(el ? ST_S0 : st);
                    if (!el) begin
                        u_part.press(SHORT);
                        expect_st(ST_S0);
                    end
                end
            end
        end
        $display("test wake done");
        rd(ADDR_INT_STAT, v);
        wr(ADDR_INT_MASK, 32'h1);
        // let the mask write settle before looking at the line
        @(negedge clock);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_CMD, {29'h0, ST_S1});
        expect_st(ST_S1);
        check({31'h0, irq}, 32'h1);
        rd(ADDR_INT_STAT, v);
        check(v & 32'h1, 32'h1);
        check({31'h0, irq}, 32'h0);
        wr(ADDR_INT_MASK, 32'h0);
        wr(ADDR_CMD, {29'h0, ST_S0});
        expect_st(ST_S0);
        check({31'h0, irq}, 32'h0);
        $display("test interrupt done");
        // single-colour indicator, S1 on short press, refused command
        dual_led = 1'b0;
        wr(ADDR_CTRL, 32'h0E);
        u_part.press(SHORT);
        expect_st(ST_S1);
        wr(ADDR_CMD, {29'h0, ST_S3});
        expect_st(ST_S1);
        u_part.press(SHORT);
        expect_st(ST_S0);
        wr(ADDR_CMD, {29'h0, ST_S3});
        expect_st(ST_S3);
        u_part.press(SHORT);
        expect_st(ST_S0);
        $display("test single led done");
        u_part.set_ac(1'b0);
        expect_st(ST_G3);
        check({31'h0, led_standby}, 32'h0);
        rd(ADDR_INT_STAT, v);
        check(v & 32'h10, 32'h10);
        u_part.set_ac(1'b1);
        expect_st(ST_S0);
        wr(ADDR_CMD, {29'h0, ST_S5});
        expect_st(ST_S5);
        check({31'h0, led_standby}, 32'h1);
        u_part.set_ac(1'b0);
        expect_st(ST_G3);
        u_part.set_ac(1'b1);
        expect_st(ST_S5);
        $display("test ac done");
        wrap_up();
    end
endmodule
`default_nettype wire
